// file: logic/csr_reporter.sv
// Purpose: calibration result word with apb access and interrupt
// Assumes: sequencer signals synchronous to i_clk_sys
// Notes: result word is read-only; event bits write-one-to-clear
`timescale 1ns/1ps
module csr_reporter #(
  parameter int NUM_SUBBLK = 3
)
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_cal_start,
  input wire logic i_cal_success,
  input wire logic i_cal_fail,
  input wire csr_pkg::csr_stage_type i_stage,
  input wire csr_pkg::csr_subblk_type [NUM_SUBBLK-1:0] i_subblk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_cal_done
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  // two stages so release is clean against the clock
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rstn = rst_sync_reg;

  // ----------------------------------------------------------------
  // failing sub-block lookup
  // ----------------------------------------------------------------
  logic [7:0] subcode_next;
  logic any_err;
  // lowest-index flagged sub-block wins if several flag at once
  always_comb
  begin
    subcode_next = 8'h00;
    any_err = 1'b0;
    for (int i = NUM_SUBBLK - 1; i >= 0; i--)
    begin
      if (i_subblk[i].err)
      begin
        subcode_next = i_subblk[i].result;
        any_err = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------
  csr_pkg::csr_fsm_type state_reg;
  logic fail_evt;
  logic pass_evt;
  assign fail_evt = (state_reg == csr_pkg::CSR_ST_RUN) && i_cal_fail;
  assign pass_evt = (state_reg == csr_pkg::CSR_ST_RUN) && i_cal_success && !i_cal_fail;
  // a start restarts from any state; fail beats success
  always_ff @(posedge i_clk_sys or negedge rstn)
  begin
    if (!rstn)
      state_reg <= csr_pkg::CSR_ST_IDLE;
    else if (i_cal_start)
      state_reg <= csr_pkg::CSR_ST_RUN;
    else
    begin
      unique case (state_reg)
        csr_pkg::CSR_ST_IDLE: state_reg <= csr_pkg::CSR_ST_IDLE;
        csr_pkg::CSR_ST_RUN:
        begin
          if (fail_evt)
            state_reg <= csr_pkg::CSR_ST_FAIL;
          else if (pass_evt)
            state_reg <= csr_pkg::CSR_ST_PASS;
        end
        csr_pkg::CSR_ST_PASS: state_reg <= csr_pkg::CSR_ST_PASS;
        csr_pkg::CSR_ST_FAIL: state_reg <= csr_pkg::CSR_ST_FAIL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result word
  // ----------------------------------------------------------------
  logic [31:0] result_reg;
  logic [31:0] result_next;
  // only stage and subcode bytes carry content; other bytes read zero
  always_comb
  begin
    result_next = 32'h0000_0000;
    result_next[csr_pkg::CSR_STAGE_LSB +: 8] = i_stage;
    result_next[csr_pkg::CSR_SUBCODE_LSB +: 8] = any_err ? subcode_next : 8'h00;
  end
  // latched once per run; start clears so stale results never show
  always_ff @(posedge i_clk_sys or negedge rstn)
  begin
    if (!rstn)
      result_reg <= csr_pkg::CSR_RESULT_RST;
    else if (i_cal_start)
      result_reg <= csr_pkg::CSR_RESULT_RST;
    else if (fail_evt)
      result_reg <= result_next;
    else if (pass_evt)
      result_reg <= csr_pkg::CSR_RESULT_RST;
  end

  // ----------------------------------------------------------------
  // events, mask and interrupt
  // ----------------------------------------------------------------
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  // set beats a same-cycle write-one clear
  always_ff @(posedge i_clk_sys or negedge rstn)
  begin
    if (!rstn)
      status_reg <= 2'h0;
    else
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (b == csr_pkg::CSR_EV_PASS && pass_evt)
          status_reg[b] <= 1'b1;
        else if (b == csr_pkg::CSR_EV_FAIL && fail_evt)
          status_reg[b] <= 1'b1;
        else if (wr_acc && paddr == csr_pkg::CSR_ADDR_STATUS && pwdata[b])
          status_reg[b] <= 1'b0;
      end
    end
  end
  // mask: 1 enables the event onto the interrupt
  always_ff @(posedge i_clk_sys or negedge rstn)
  begin
    if (!rstn)
      mask_reg <= csr_pkg::CSR_MASK_RST;
    else if (wr_acc && paddr == csr_pkg::CSR_ADDR_MASK)
      mask_reg <= pwdata[1:0];
  end
  // registered so the pin is glitch free, one cycle behind status
  always_ff @(posedge i_clk_sys or negedge rstn)
  begin
    if (!rstn)
      o_irq <= 1'b0;
    else
      o_irq <= |(status_reg & mask_reg);
  end
  always_ff @(posedge i_clk_sys or negedge rstn)
  begin
    if (!rstn)
      o_cal_done <= 1'b0;
    else
      o_cal_done <= (state_reg == csr_pkg::CSR_ST_PASS) || (state_reg == csr_pkg::CSR_ST_FAIL);
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic map_hit;
  logic ro_hit;
  always_comb
  begin
    map_hit = (paddr == csr_pkg::CSR_ADDR_RESULT) || (paddr == csr_pkg::CSR_ADDR_STATUS)
           || (paddr == csr_pkg::CSR_ADDR_MASK) || (paddr == csr_pkg::CSR_ADDR_STATE);
    ro_hit = (paddr == csr_pkg::CSR_ADDR_RESULT) || (paddr == csr_pkg::CSR_ADDR_STATE);
  end
  // pready registered during setup so it is high in the first access cycle
  always_ff @(posedge i_clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= psel && !penable;
      o_pslverr <= psel && !penable && (!map_hit || (pwrite && ro_hit));
    end
  end
  // read data prepared during setup; unmapped reads zero
  always_ff @(posedge i_clk_sys or negedge rstn)
  begin
    if (!rstn)
      o_prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        csr_pkg::CSR_ADDR_RESULT: o_prdata <= result_reg;
        csr_pkg::CSR_ADDR_STATUS: o_prdata <= {30'h0, status_reg};
        csr_pkg::CSR_ADDR_MASK: o_prdata <= {30'h0, mask_reg};
        csr_pkg::CSR_ADDR_STATE: o_prdata <= {30'h0, state_reg};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pass_zero_fields: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    pass_evt && !i_cal_start |=> result_reg[7:0] == 8'h00 && result_reg[23:16] == 8'h00)
    else $error("passing run left nonzero fields");
  a_fail_stage_code: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    fail_evt && !i_cal_start |=> result_reg[7:0] == $past(i_stage))
    else $error("stage byte wrong after fail");
  a_fail_subcode: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    fail_evt && !i_cal_start && i_subblk[0].err |=> result_reg[23:16] == $past(i_subblk[0].result))
    else $error("subcode byte wrong after fail");
  a_result_held: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    state_reg == csr_pkg::CSR_ST_FAIL && !i_cal_start |=> $stable(result_reg))
    else $error("result changed without a new run");
  a_result_ro: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    wr_acc && paddr == csr_pkg::CSR_ADDR_RESULT && !i_cal_start && !fail_evt && !pass_evt
    |=> $stable(result_reg))
    else $error("write altered result word");
  a_result_read: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    psel && !penable && !pwrite && paddr == csr_pkg::CSR_ADDR_RESULT
    |=> o_pready && o_prdata == $past(result_reg))
    else $error("result read mismatch");
  a_unused_bytes: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    result_reg[15:8] == 8'h00 && result_reg[31:24] == 8'h00)
    else $error("unused bytes nonzero");
  a_stage_range: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    state_reg == csr_pkg::CSR_ST_FAIL |-> result_reg[7:0] <= 8'h10)
    else $error("stage code out of range");
  a_irq_fail: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    fail_evt && mask_reg[1] ##1 mask_reg[1] |=> o_irq)
    else $error("fail event did not raise irq");

  // ----------------------------------------------------------------
  // run and event checks
  // ----------------------------------------------------------------
  // start wipes the previous outcome so a rerun never shows stale data
  a_start_clears: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    i_cal_start |=> result_reg == csr_pkg::CSR_RESULT_RST && state_reg == csr_pkg::CSR_ST_RUN)
    else $error("start did not clear the result");
  a_idle_pass_held: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    (state_reg == csr_pkg::CSR_ST_IDLE || state_reg == csr_pkg::CSR_ST_PASS) && !i_cal_start
    |=> $stable(result_reg))
    else $error("result moved outside a run");
  a_fail_state: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    fail_evt && !i_cal_start |=> state_reg == csr_pkg::CSR_ST_FAIL)
    else $error("fail did not end the run");
  a_pass_state: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    pass_evt && !i_cal_start |=> state_reg == csr_pkg::CSR_ST_PASS)
    else $error("pass did not end the run");

  // event flags: a set in the same cycle as a write-one clear wins
  a_fail_flag_set: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    fail_evt |=> status_reg[csr_pkg::CSR_EV_FAIL])
    else $error("fail flag not set");
  a_pass_flag_set: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    pass_evt |=> status_reg[csr_pkg::CSR_EV_PASS])
    else $error("pass flag not set");
  a_irq_masked: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    mask_reg == 2'h0 |=> !o_irq)
    else $error("irq raised while fully masked");
  a_done_level: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    state_reg == csr_pkg::CSR_ST_FAIL || state_reg == csr_pkg::CSR_ST_PASS |=> o_cal_done)
    else $error("done flag missing after run end");

  // bus answers: no wait states, refusals flagged alongside ready
  a_ready_access: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    psel && !penable |=> o_pready)
    else $error("no ready in access cycle");
  a_no_stray_ready: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    !psel |=> !o_pready)
    else $error("ready without a transfer");
  a_ro_write_err: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    psel && !penable && pwrite && paddr == csr_pkg::CSR_ADDR_RESULT |=> o_pready && o_pslverr)
    else $error("write to result word not refused");
  a_state_read: assert property (@(posedge i_clk_sys) disable iff (!rstn)
    psel && !penable && !pwrite && paddr == csr_pkg::CSR_ADDR_STATE
    |=> o_prdata == {30'h0, $past(state_reg)})
    else $error("run state read mismatch");
endmodule

// file: shared/csr_pkg.sv
// Purpose: shared constants and types for the calibration status reporter
// Assumes: 32-bit apb data, word-aligned registers
// Notes: register offsets are a local choice, one aligned word each
package csr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CSR_ADDR_RESULT = 12'h000;
  localparam logic [11:0] CSR_ADDR_STATUS = 12'h004;
  localparam logic [11:0] CSR_ADDR_MASK = 12'h008;
  localparam logic [11:0] CSR_ADDR_STATE = 12'h00c;
  localparam logic [31:0] CSR_RESULT_RST = 32'h0000_0000;
  localparam logic [1:0] CSR_MASK_RST = 2'h0;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CSR_STAGE_LSB = 0;
  localparam int CSR_SUBCODE_LSB = 16;
  localparam int CSR_EV_PASS = 0;
  localparam int CSR_EV_FAIL = 1;
  // ----------------------------------------------------------------
  // stage codes
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    CSR_STG_ENTER = 8'h00,
    CSR_STG_PHY_INIT = 8'h01,
    CSR_STG_DRAM_INIT = 8'h02,
    CSR_STG_HDR_WRITE = 8'h03,
    CSR_STG_BURST_PAT = 8'h04,
    CSR_STG_MORE_PAT = 8'h05,
    CSR_STG_TEST_PAT = 8'h06,
    CSR_STG_RSYNC_RST = 8'h07,
    CSR_STG_RSYNC_SWEEP = 8'h08,
    CSR_STG_RSYNC_SEEK = 8'h09,
    CSR_STG_RDV = 8'h0a,
    CSR_STG_POSTAMBLE = 8'h0b,
    CSR_STG_WR_PATH = 8'h0c,
    CSR_STG_OUT_RLAT = 8'h0d,
    CSR_STG_OUT_WLAT = 8'h0e,
    CSR_STG_CUST_MR = 8'h0f,
    CSR_STG_TRACKING = 8'h10
  } csr_stage_type;
  // sub-block error flags and result buses
  typedef struct packed {
    logic err;
    logic [7:0] result;
  } csr_subblk_type;
  typedef enum logic [1:0] {
    CSR_ST_IDLE = 2'b00,
    CSR_ST_RUN = 2'b01,
    CSR_ST_PASS = 2'b10,
    CSR_ST_FAIL = 2'b11
  } csr_fsm_type;
endpackage

// file: verification/csr_reporter_bench.sv
// Purpose: self-checking bench for the calibration result reporter
// Assumes: apb slave answers in its own time, sequencer inputs on i_clk_sys
// Notes: apb ready and read data are taken at the rising edge that shows ready
`timescale 1ns/1ps
module csr_reporter_bench;
  // ----------------------------------------------------------------
  // stimulus signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn;
  logic start = 1'b0;
  logic succ = 1'b0;
  logic fail = 1'b0;
  csr_pkg::csr_stage_type stage = csr_pkg::CSR_STG_ENTER;
  csr_pkg::csr_subblk_type [2:0] sub = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic done;
  int fails = 0;
  int check_count = 0;
  logic [31:0] last;
  // 100 mhz clock
  always #5 clk = ~clk;
  csr_reporter #(.NUM_SUBBLK(3)) i_csr_reporter (.i_clk_sys(clk), .i_rstn(rstn),
    .i_cal_start(start), .i_cal_success(succ), .i_cal_fail(fail), .i_stage(stage),
    .i_subblk(sub), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_irq(irq), .o_cal_done(done));
  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // one apb transfer; request held until ready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      chk1("pready", 1'b1, pready);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0000_0000, r, er);
    chk32("prdata", e, r);
    chk1("pslverr", ee, er);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    chk1("pslverr", ee, er);
  endtask
  // one calibration run ending in pass or fail at the given stage
  task cal(input logic f, input logic [7:0] s);
    @(posedge clk);
    start <= 1'b1;
    stage <= csr_pkg::csr_stage_type'(s);
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    fail <= f;
    succ <= ~f;
    @(posedge clk);
    fail <= 1'b0;
    succ <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog, generous against a run of a few hundred cycles
  // ----------------------------------------------------------------
  initial
  begin
    #200000;
    fails++;
    test_done();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    // edge at time zero so the asynchronous reset fires before any clock
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(csr_pkg::CSR_ADDR_RESULT, csr_pkg::CSR_RESULT_RST, 1'b0);
    rd(csr_pkg::CSR_ADDR_STATE, 32'h0000_0000, 1'b0);
    rd(csr_pkg::CSR_ADDR_MASK, 32'h0000_0000, 1'b0);
    rd(csr_pkg::CSR_ADDR_STATUS, 32'h0000_0000, 1'b0);
    chk1("irq", 1'b0, irq);
    chk1("cal_done", 1'b0, done);
    $display("test reset done");
    // every stage code; lowest flagged sub-block supplies the subcode
    for (int s = 0; s <= 16; s++)
    begin
      sub[0] <= '{err: 1'b0, result: 8'h55};
      sub[1] <= '{err: 1'b1, result: 8'(8'h40 + s)};
      sub[2] <= '{err: 1'b1, result: 8'hee};
      cal(1'b1, 8'(s));
      last = {8'h00, 8'(8'h40 + s), 8'h00, 8'(s)};
      rd(csr_pkg::CSR_ADDR_RESULT, last, 1'b0);
      rd(csr_pkg::CSR_ADDR_STATE, 32'h0000_0003, 1'b0);
      chk1("cal_done", 1'b1, done);
    end
    $display("test stage codes done");
    // success outside a run must be ignored, writes refused
    @(posedge clk);
    succ <= 1'b1;
    @(posedge clk);
    succ <= 1'b0;
    wr(csr_pkg::CSR_ADDR_RESULT, 32'hffff_ffff, 1'b1);
    rd(csr_pkg::CSR_ADDR_RESULT, last, 1'b0);
    rd(12'h010, 32'h0000_0000, 1'b1);
    $display("test hold done");
    // fail event: mask, raise, clear
    chk1("irq", 1'b0, irq);
    wr(csr_pkg::CSR_ADDR_MASK, 32'h0000_0002, 1'b0);
    repeat (2) @(posedge clk);
    chk1("irq", 1'b1, irq);
    wr(csr_pkg::CSR_ADDR_STATUS, 32'h0000_0002, 1'b0);
    rd(csr_pkg::CSR_ADDR_STATUS, 32'h0000_0000, 1'b0);
    chk1("irq", 1'b0, irq);
    // unmasked fail: lowest sub-block now flags and wins
    sub[0] <= '{err: 1'b1, result: 8'h17};
    cal(1'b1, 8'h07);
    chk1("irq", 1'b1, irq);
    last = 32'h0017_0007;
    rd(csr_pkg::CSR_ADDR_RESULT, last, 1'b0);
    wr(csr_pkg::CSR_ADDR_STATUS, 32'h0000_0002, 1'b0);
    $display("test fail irq done");
    // a start alone opens a run and wipes the old result
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    rd(csr_pkg::CSR_ADDR_STATE, 32'h0000_0001, 1'b0);
    rd(csr_pkg::CSR_ADDR_RESULT, csr_pkg::CSR_RESULT_RST, 1'b0);
    chk1("cal_done", 1'b0, done);
    // pass clears both fields even with stale stage and error flags
    cal(1'b0, 8'h0c);
    rd(csr_pkg::CSR_ADDR_RESULT, 32'h0000_0000, 1'b0);
    rd(csr_pkg::CSR_ADDR_STATE, 32'h0000_0002, 1'b0);
    rd(csr_pkg::CSR_ADDR_STATUS, 32'h0000_0001, 1'b0);
    chk1("irq", 1'b0, irq);
    wr(csr_pkg::CSR_ADDR_MASK, 32'h0000_0001, 1'b0);
    repeat (2) @(posedge clk);
    chk1("irq", 1'b1, irq);
    wr(csr_pkg::CSR_ADDR_STATUS, 32'h0000_0001, 1'b0);
    repeat (2) @(posedge clk);
    chk1("irq", 1'b0, irq);
    $display("test pass done");
    test_done();
  end
endmodule
